// [rtl/acp_pkg.sv]
// Constants, types and timing of the asynchronous peripheral configuration port
//////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Both selects plus read strobe drive status
// - Status bit7 ready high, bits 0-6 high
// - Bit7 mirrors ready when selected and idle
// - No final byte, start-up never completes
// - Program low keeps clearing configuration memory
// - Program high: one more clear, then configure
// - Program low forces init output low
// - Init held low: clear, then wait
// - Init released: sample mode bits, get ready
// - Master waits up to 250 us more
// - Busy lasts 2 to 9 clock periods
// - Byte handling waits on previous byte, phase
// - Power-on-reset interval chosen by mode bits
// - Config clock delay and period by rate; code: delay fixed at CONFIG_CLOCK_DELAY_US, only period by rate
// - Busy on receive, ready after buffer transfer
// - Bytes double-buffered, then shifted out serially
//////////////////////////////////////////////////////////////////////////////////////////////
package acp_pkg;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned LEN_W         = 16;
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned DIV_W         = 6;
   localparam int unsigned FIFO_DEPTH    = 32;
   localparam int unsigned FIFO_WIDTH    = 1;

   // Synchronised pin vector layout
   localparam int unsigned PIN_CS_LOW_N  = 0;
   localparam int unsigned PIN_CS_HIGH   = 1;
   localparam int unsigned PIN_RS_N      = 2;
   localparam int unsigned PIN_WS_N      = 3;
   localparam int unsigned PIN_PROG_N    = 4;
   localparam int unsigned PIN_INIT      = 5;
   localparam int unsigned PIN_MODE      = 6;
   localparam int unsigned PIN_FAST      = 9;
   localparam int unsigned PIN_DATA      = 10;
   localparam int unsigned PIN_W         = 18;

   // Mode codes, M2:M1:M0
   localparam logic [2:0] MODE_MASTER_SER  = 3'h0;
   localparam logic [2:0] MODE_MASTER_LOW  = 3'h4;
   localparam logic [2:0] MODE_MASTER_HIGH = 3'h6;

   localparam logic [7:0] STATUS_LOW_BITS = 8'h7f;
   localparam logic [7:0] OE_ALL_OFF      = 8'hff;
   localparam logic [7:0] OE_ALL_ON       = 8'h00;
   localparam logic [7:0] OE_D7_ONLY      = 8'h7f;
   localparam int unsigned STATUS_RDY_BIT = 7;

   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned POR_SLAVE_MS    = 10;
   localparam int unsigned POR_M0_HIGH_MS  = 10;
   localparam int unsigned POR_M0_LOW_MS   = 40;
   localparam int unsigned MASTER_WAIT_US  = 250;
   localparam int unsigned CONFIG_CLOCK_DELAY_US   = 40;
   localparam int unsigned CONFIG_CLOCK_SLOW_NS    = 640;
   localparam int unsigned CONFIG_CLOCK_FAST_NS    = 100;
   localparam int unsigned CLEAR_CYCLES    = 64;

   localparam int unsigned POR_SLAVE_CYC   = (POR_SLAVE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POR_M0_HIGH_CYC = (POR_M0_HIGH_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POR_M0_LOW_CYC  = (POR_M0_LOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MASTER_WAIT_CYC = (MASTER_WAIT_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CONFIG_CLOCK_DELAY_CYC  = (CONFIG_CLOCK_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HALF_SLOW_CYC   = (CONFIG_CLOCK_SLOW_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int unsigned HALF_FAST_CYC   = (CONFIG_CLOCK_FAST_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_POR,
      ST_CLEAR,
      ST_INIT_WAIT,
      ST_MASTER_WAIT,
      ST_CONFIG_CLOCK_DELAY,
      ST_LOAD,
      ST_DONE
   } acp_state_t;
endpackage : acp_pkg

// [rtl/acp_fifo.sv]
// Parameterised FIFO with registered output stage
`timescale 1ns/10ps
module acp_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        ov;
      logic [WIDTH-1:0]            od;
   } acp_fifo_t;

   acp_fifo_t r;
   acp_fifo_t next_r;
   logic      push;
   logic      pop;

   assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid = r.ov;
   assign out_data  = r.od;

   always_comb begin
      next_r = r;
      push   = in_valid && in_ready;
      pop    = (r.cnt != '0) && (!r.ov || out_ready);
      if (r.ov && out_ready) begin
         next_r.ov = 1'b0;
      end
      if (pop) begin
         next_r.od = r.mem[r.rp];
         next_r.ov = 1'b1;
         next_r.rp = r.rp + AW'(1);
      end
      if (push) begin
         next_r.mem[r.wp] = in_data;
         next_r.wp        = r.wp + AW'(1);
      end
      next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : acp_fifo

// [rtl/acp_config_port.sv]
// Asynchronous peripheral configuration port: host byte interface, start-up sequencing, serialiser
`timescale 1ns/10ps
module acp_config_port
   import acp_pkg::*;
#(
   parameter int unsigned POR_SLAVE_CYCLES   = acp_pkg::POR_SLAVE_CYC,
   parameter int unsigned POR_M0_HIGH_CYCLES = acp_pkg::POR_M0_HIGH_CYC,
   parameter int unsigned POR_M0_LOW_CYCLES  = acp_pkg::POR_M0_LOW_CYC,
   parameter int unsigned MASTER_WAIT_CYCLES = acp_pkg::MASTER_WAIT_CYC
) (
   // Clock and reset
   input  wire logic                        CLK,
   input  wire logic                        ARST_N,
   // Host bus pins
   input  wire logic                        CHIP_SELECT_LOW_N,
   input  wire logic                        CHIP_SELECT_HIGH,
   input  wire logic                        STATUS_READ_STROBE_N,
   input  wire logic                        WRITE_STROBE_N,
   input  wire logic [acp_pkg::BYTE_W-1:0]  DATA_IN,
   output logic      [acp_pkg::BYTE_W-1:0]  DATA_OUT,
   output logic      [acp_pkg::BYTE_W-1:0]  DATA_OE_N,
   output logic                             READY_BUSY,
   // Start-up control pins
   input  wire logic                        PROGRAM_N,
   input  wire logic                        INIT_IN,
   output logic                             INIT_OUT,
   output logic                             INIT_OE_N,
   input  wire logic [2:0]                  MODE_BITS,
   input  wire logic                        FAST_RATE,
   // Configuration length and progress
   input  wire logic [acp_pkg::LEN_W-1:0]   LENGTH_COUNT,
   output logic      [2:0]                  MODE_CAPTURED,
   output logic                             MEM_CLEAR,
   output logic                             INTERNAL_RESET,
   output logic                             STARTUP_DONE,
   output logic                             CONFIG_CLOCK,
   // Serial configuration stream
   output logic                             CFG_BIT,
   output logic                             CFG_BIT_VALID,
   input  wire logic                        CFG_BIT_READY
);
   import acp_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0]  s1;
      logic [PIN_W-1:0]  s2;
      acp_state_t        st;
      logic [CNT_W-1:0]  cnt;
      logic [DIV_W-1:0]  div;
      logic              config_clock;
      logic              wr_act;
      logic [BYTE_W-1:0] wr_data;
      logic              in_full;
      logic              in_aged;
      logic [BYTE_W-1:0] in_byte;
      logic              sh_full;
      logic [BYTE_W-1:0] sh_reg;
      logic [2:0]        sh_bits;
      logic [LEN_W-1:0]  bytes;
      logic [2:0]        mode;
      logic [BYTE_W-1:0] d_out;
      logic [BYTE_W-1:0] d_oe_n;
      logic              init_oe_n;
      logic              rdy;
      logic              memclr;
      logic              irst;
      logic              done;
   } acp_top_t;

   localparam acp_top_t RESET_VAL = '{
      s1:        '0,
      s2:        '0,
      st:        ST_POR,
      cnt:       '0,
      div:       '0,
      config_clock:      1'b1,
      wr_act:    1'b0,
      wr_data:   '0,
      in_full:   1'b0,
      in_aged:   1'b0,
      in_byte:   '0,
      sh_full:   1'b0,
      sh_reg:    '0,
      sh_bits:   '0,
      bytes:     '0,
      mode:      '0,
      d_out:     '0,
      d_oe_n:    OE_ALL_OFF,
      init_oe_n: 1'b0,
      rdy:       1'b1,
      memclr:    1'b1,
      irst:      1'b1,
      done:      1'b0
   };

   acp_top_t r;
   acp_top_t next_r;

   logic             cs_ok;
   logic             wr_on;
   logic             rd_on;
   logic             prog_n;
   logic             init_hi;
   logic [2:0]       mode_pin;
   logic             pin_master;
   logic             cap_master;
   logic [CNT_W-1:0] por_len;
   logic [DIV_W-1:0] half;
   logic             tick;
   logic             fifo_valid;
   logic             fifo_ready;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Serial stream buffer toward the configuration logic
   acp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .arst_n    (ARST_N),
      .in_valid  (fifo_valid),
      .in_data   (r.sh_reg[BYTE_W-1]),
      .in_ready  (fifo_ready),
      .out_valid (CFG_BIT_VALID),
      .out_data  (CFG_BIT),
      .out_ready (CFG_BIT_READY)
   );

   //////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_r     = r;
      next_r.s1  = {DATA_IN, FAST_RATE, MODE_BITS, INIT_IN, PROGRAM_N,
                    WRITE_STROBE_N, STATUS_READ_STROBE_N, CHIP_SELECT_HIGH, CHIP_SELECT_LOW_N};
      next_r.s2  = r.s1;
      cs_ok      = !r.s2[PIN_CS_LOW_N] && r.s2[PIN_CS_HIGH];
      wr_on      = cs_ok && !r.s2[PIN_WS_N] && r.s2[PIN_RS_N];
      rd_on      = cs_ok && !r.s2[PIN_RS_N];
      prog_n     = r.s2[PIN_PROG_N];
      init_hi    = r.s2[PIN_INIT];
      mode_pin   = r.s2[PIN_MODE +: 3];
      pin_master = (mode_pin == MODE_MASTER_SER) || (mode_pin == MODE_MASTER_LOW)
                   || (mode_pin == MODE_MASTER_HIGH);
      cap_master = (r.mode == MODE_MASTER_SER) || (r.mode == MODE_MASTER_LOW)
                   || (r.mode == MODE_MASTER_HIGH);
      if (!pin_master) begin
         por_len = CNT_W'(POR_SLAVE_CYCLES);
      end else if (mode_pin[0]) begin
         por_len = CNT_W'(POR_M0_HIGH_CYCLES);
      end else begin
         por_len = CNT_W'(POR_M0_LOW_CYCLES);
      end
      half       = r.s2[PIN_FAST] ? DIV_W'(HALF_FAST_CYC) : DIV_W'(HALF_SLOW_CYC);
      tick       = 1'b0;
      fifo_valid = 1'b0;

      // Sequencer
      case (r.st)
         ST_POR: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt >= por_len - CNT_W'(1)) begin
               next_r.st  = ST_CLEAR;
               next_r.cnt = '0;
            end
         end
         ST_CLEAR: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (!prog_n) begin
               next_r.cnt = '0;
            end else if (r.cnt == CNT_W'(CLEAR_CYCLES - 1)) begin
               next_r.st  = ST_INIT_WAIT;
               next_r.cnt = '0;
            end
         end
         ST_INIT_WAIT: begin
            if (init_hi) begin
               next_r.mode = mode_pin;
               next_r.st   = pin_master ? ST_MASTER_WAIT : ST_CONFIG_CLOCK_DELAY;
            end
         end
         ST_MASTER_WAIT: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt == CNT_W'(MASTER_WAIT_CYCLES - 1)) begin
               next_r.st  = ST_CONFIG_CLOCK_DELAY;
               next_r.cnt = '0;
            end
         end
         ST_CONFIG_CLOCK_DELAY: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt == CNT_W'(CONFIG_CLOCK_DELAY_CYC - 1)) begin
               next_r.st  = ST_LOAD;
               next_r.cnt = '0;
               next_r.div = '0;
            end
         end
         ST_LOAD: begin
            // Config clock divider; rising edge is the work tick
            if (r.div >= half - DIV_W'(1)) begin
               next_r.div  = '0;
               next_r.config_clock = !r.config_clock;
               tick        = !r.config_clock;
            end else begin
               next_r.div = r.div + DIV_W'(1);
            end
            // Byte accepted on the trailing edge of the write condition
            if (wr_on) begin
               next_r.wr_data = r.s2[PIN_DATA +: BYTE_W];
            end
            if (r.wr_act && !wr_on && !r.in_full) begin
               next_r.in_full = 1'b1;
               next_r.in_aged = 1'b0;
               next_r.in_byte = r.wr_data;
            end
            // Shift register feeds one bit per tick while the FIFO has room
            if (tick && r.sh_full) begin
               fifo_valid = 1'b1;
               if (fifo_ready) begin
                  next_r.sh_reg  = {r.sh_reg[BYTE_W-2:0], 1'b0};
                  next_r.sh_bits = r.sh_bits + 3'h1;
                  if (r.sh_bits == 3'h7) begin
                     next_r.sh_full = 1'b0;
                  end
               end
            end
            // Input buffer hands over on the second tick after capture, once shifter is empty
            if (tick && r.in_full) begin
               if (!r.in_aged) begin
                  next_r.in_aged = 1'b1;
               end else if (!r.sh_full) begin
                  next_r.sh_reg  = r.in_byte;
                  next_r.sh_full = 1'b1;
                  next_r.sh_bits = '0;
                  next_r.in_full = 1'b0;
                  next_r.bytes   = r.bytes + LEN_W'(1);
               end
            end
            if ((r.bytes == LENGTH_COUNT) && !r.in_full && !r.sh_full) begin
               next_r.st   = ST_DONE;
               next_r.config_clock = 1'b1;
            end
         end
         ST_DONE: begin
            next_r.config_clock = 1'b1;
         end
         default: begin
            next_r.st = ST_POR;
         end
      endcase
      next_r.wr_act = wr_on && (r.st == ST_LOAD);

      // Program low restarts the clear from any state after power-on
      if (!prog_n && (r.st != ST_POR)) begin
         next_r.st      = ST_CLEAR;
         next_r.cnt     = '0;
         next_r.in_full = 1'b0;
         next_r.sh_full = 1'b0;
         next_r.bytes   = '0;
         next_r.config_clock    = 1'b1;
      end

      // Outputs
      next_r.init_oe_n = !((next_r.st == ST_POR) || (next_r.st == ST_CLEAR));
      next_r.memclr    = (next_r.st == ST_POR) || (next_r.st == ST_CLEAR);
      next_r.irst      = (next_r.st != ST_DONE);
      next_r.done      = (next_r.st == ST_DONE);
      next_r.rdy       = !next_r.in_full;
      next_r.d_out     = STATUS_LOW_BITS;
      next_r.d_out[STATUS_RDY_BIT] = r.rdy;
      if (rd_on) begin
         next_r.d_oe_n = OE_ALL_ON;
      end else if (cs_ok && r.s2[PIN_WS_N]) begin
         next_r.d_oe_n = OE_D7_ONLY;
      end else begin
         next_r.d_oe_n = OE_ALL_OFF;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r <= RESET_VAL;
      end else begin
         r <= next_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Output wiring
   assign DATA_OUT       = r.d_out;
   assign DATA_OE_N      = r.d_oe_n;
   assign READY_BUSY     = r.rdy;
   assign INIT_OUT       = 1'b0;
   assign INIT_OE_N      = r.init_oe_n;
   assign MODE_CAPTURED  = r.mode;
   assign MEM_CLEAR      = r.memclr;
   assign INTERNAL_RESET = r.irst;
   assign STARTUP_DONE   = r.done;
   assign CONFIG_CLOCK   = r.config_clock;
endmodule : acp_config_port

// [dv/acp_checker_properties.sv]
// Concurrent checks on the configuration port pins
`timescale 1ns/10ps
module acp_checker
   import acp_pkg::*;
(
   // Clock and reset
   input wire logic              CLK,
   input wire logic              ARST_N,
   // Host bus
   input wire logic              CHIP_SELECT_LOW_N,
   input wire logic              CHIP_SELECT_HIGH,
   input wire logic              STATUS_READ_STROBE_N,
   input wire logic              WRITE_STROBE_N,
   input wire logic [BYTE_W-1:0] DATA_OUT,
   input wire logic [BYTE_W-1:0] DATA_OE_N,
   input wire logic              READY_BUSY,
   // Start-up
   input wire logic              PROGRAM_N,
   input wire logic              INIT_IN,
   input wire logic              INIT_OE_N,
   input wire logic              MEM_CLEAR,
   input wire logic              INTERNAL_RESET,
   input wire logic              STARTUP_DONE,
   input wire logic              CONFIG_CLOCK,
   // Serial stream
   input wire logic              CFG_BIT,
   input wire logic              CFG_BIT_VALID,
   input wire logic              CFG_BIT_READY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   wire logic rd  = !CHIP_SELECT_LOW_N && CHIP_SELECT_HIGH && !STATUS_READ_STROBE_N;
   wire logic sel = !CHIP_SELECT_LOW_N && CHIP_SELECT_HIGH && STATUS_READ_STROBE_N && WRITE_STROBE_N;
   //////////////////////////////////////////////////////////////////////////////
   a_read_drives: assert property (rd [*4] |-> DATA_OE_N == 8'h00)
      else $error("status read not driven");
   a_low_bits: assert property (DATA_OE_N == 8'h00 |-> DATA_OUT[6:0] == 7'h7f)
      else $error("status low bits not high");
   a_ready_mirror: assert property (!DATA_OE_N[7] |-> DATA_OUT[7] == READY_BUSY || DATA_OUT[7] == $past(READY_BUSY))
      else $error("bit 7 does not follow ready");
   a_idle_d7: assert property (sel [*4] |-> DATA_OE_N == 8'h7f)
      else $error("idle select drive wrong");
   a_prog_init: assert property (!PROGRAM_N [*4] |-> !INIT_OE_N)
      else $error("init not pulled low");
   a_prog_clear: assert property (!PROGRAM_N [*4] |-> MEM_CLEAR)
      else $error("memory not clearing");
   a_init_wait: assert property ((!INIT_IN && INTERNAL_RESET) [*4] |-> CONFIG_CLOCK && READY_BUSY)
      else $error("loading while init low");
   a_done_quiet: assert property (STARTUP_DONE |-> !INTERNAL_RESET && CONFIG_CLOCK)
      else $error("done without reset release");
   a_busy_ends: assert property ($fell(READY_BUSY) |-> ##[1:600] READY_BUSY)
      else $error("busy too long");
   a_busy_cause: assert property ($fell(READY_BUSY) |-> !$past(WRITE_STROBE_N, 3) || !$past(WRITE_STROBE_N, 4) || !$past(WRITE_STROBE_N, 5))
      else $error("busy without write");
   a_bit_hold: assert property (CFG_BIT_VALID && !CFG_BIT_READY |=> CFG_BIT_VALID && $stable(CFG_BIT))
      else $error("stalled bit changed");
   c_read: cover property (rd ##4 DATA_OE_N == 8'h00);
   c_busy: cover property ($fell(READY_BUSY));
   c_done: cover property ($rose(STARTUP_DONE));
endmodule : acp_checker
bind acp_config_port acp_checker acp_checker_inst (.CLK(CLK), .ARST_N(ARST_N),
   .CHIP_SELECT_LOW_N(CHIP_SELECT_LOW_N), .CHIP_SELECT_HIGH(CHIP_SELECT_HIGH),
   .STATUS_READ_STROBE_N(STATUS_READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_OUT(DATA_OUT),
   .DATA_OE_N(DATA_OE_N), .READY_BUSY(READY_BUSY), .PROGRAM_N(PROGRAM_N), .INIT_IN(INIT_IN),
   .INIT_OE_N(INIT_OE_N), .MEM_CLEAR(MEM_CLEAR), .INTERNAL_RESET(INTERNAL_RESET), .STARTUP_DONE(STARTUP_DONE),
   .CONFIG_CLOCK(CONFIG_CLOCK), .CFG_BIT(CFG_BIT), .CFG_BIT_VALID(CFG_BIT_VALID), .CFG_BIT_READY(CFG_BIT_READY));

// [dv/acp_host_model.sv]
// Host microprocessor bus model for the configuration port
`timescale 1ns/10ps
module acp_host_model (
   // Clock
   input  wire logic       clk,
   // Device answer
   input  wire logic [7:0] dout,
   input  wire logic [7:0] oe_n,
   // Bus pins
   output logic            csl_n,
   output logic            csh,
   output logic            rs_n,
   output logic            ws_n,
   output logic      [7:0] data
);
   initial begin
      csl_n = 1'b1;
      csh   = 1'b0;
      rs_n  = 1'b1;
      ws_n  = 1'b1;
      data  = 8'h00;
   end
   // Write held five clocks, then released
   task automatic write_byte(input logic [7:0] b);
      @(posedge clk);
      csl_n <= 1'b0;
      csh   <= 1'b1;
      ws_n  <= 1'b0;
      data  <= b;
      repeat (5) @(posedge clk);
      csl_n <= 1'b1;
      csh   <= 1'b0;
      ws_n  <= 1'b1;
      data  <= ~b;
   endtask : write_byte
   // Selected with read strobe as given, sampled after sync delay
   task automatic peek(input logic strobe_n, output logic [7:0] d, output logic [7:0] oe);
      @(posedge clk);
      csl_n <= 1'b0;
      csh   <= 1'b1;
      rs_n  <= strobe_n;
      repeat (5) @(posedge clk);
      d = dout;
      oe = oe_n;
      csl_n <= 1'b1;
      csh   <= 1'b0;
      rs_n  <= 1'b1;
   endtask : peek
endmodule : acp_host_model

// [dv/tb.sv]
// Self-checking bench for the configuration port
`timescale 1ns/10ps
module tb;
   import acp_pkg::*;
   typedef struct packed { logic [7:0] data; logic fast; } acp_row_t;
   localparam int NROWS = 6;
   localparam acp_row_t ROWS [NROWS] = '{'{8'ha5, 1'h0}, '{8'h01, 1'h0}, '{8'h80, 1'h0},
                                         '{8'hff, 1'h1}, '{8'h00, 1'h1}, '{8'h3c, 1'h1}};
   logic       CLK = 1'b0;
   logic       ARST_N = 1'b0;
   logic       csl_n, csh, rs_n, ws_n;
   logic [7:0] din, dout, oe_n;
   logic       ready_busy, init_oe_n, init_out, mem_clear, int_reset, done, cfg_clk, cfg_bit, cfg_valid;
   logic [15:0] len_count = 16'(NROWS);
   logic       program_n = 1'b1;
   logic       ext_hold = 1'b0;
   logic       fast = 1'b0;
   logic       bit_ready = 1'b1;
   logic [2:0] mode_bits = 3'h5;
   logic [2:0] mode_cap;
   logic [7:0] cyc = 8'h00;
   logic       bits [$];
   int         n_errors = 0;
   int         n_compared = 0;
   // Open-drain init wire
   wire logic  init_wire = !((init_oe_n === 1'b0 && init_out === 1'b0) || ext_hold);
   always #10 CLK = ~CLK;
   acp_config_port #(.POR_SLAVE_CYCLES(20), .POR_M0_HIGH_CYCLES(20), .POR_M0_LOW_CYCLES(40),
                     .MASTER_WAIT_CYCLES(10)) acp_config_port_inst (
      .CLK(CLK), .ARST_N(ARST_N), .CHIP_SELECT_LOW_N(csl_n), .CHIP_SELECT_HIGH(csh),
      .STATUS_READ_STROBE_N(rs_n), .WRITE_STROBE_N(ws_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n),
      .READY_BUSY(ready_busy), .PROGRAM_N(program_n), .INIT_IN(init_wire), .INIT_OUT(init_out), .INIT_OE_N(init_oe_n),
      .MODE_BITS(mode_bits), .FAST_RATE(fast), .LENGTH_COUNT(len_count), .MODE_CAPTURED(mode_cap),
      .MEM_CLEAR(mem_clear), .INTERNAL_RESET(int_reset), .STARTUP_DONE(done), .CONFIG_CLOCK(cfg_clk),
      .CFG_BIT(cfg_bit), .CFG_BIT_VALID(cfg_valid), .CFG_BIT_READY(bit_ready));
   acp_host_model acp_host_model_inst (.clk(CLK), .dout(dout), .oe_n(oe_n), .csl_n(csl_n), .csh(csh),
      .rs_n(rs_n), .ws_n(ws_n), .data(din));
   // Stream sink, stalls one cycle in eight
   always @(posedge CLK) begin
      cyc <= cyc + 8'h01;
      bit_ready <= (cyc[2:0] != 3'h0);
      if (cfg_valid === 1'b1 && bit_ready === 1'b1) bits.push_back(cfg_bit);
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   function automatic logic cond(input int k);
      case (k)
         0: return ready_busy === 1'b0;
         1: return ready_busy === 1'b1;
         2: return cfg_clk === 1'b0;
         3: return done === 1'b1;
         4: return mode_cap === 3'h4;
         default: return bits.size() >= 8 * NROWS;
      endcase
   endfunction : cond
   task automatic wait_until(input int k, input int lim);
      int i;
      for (i = 0; i < lim && !cond(k); i++) @(posedge CLK);
      if (!cond(k)) begin
         n_errors++;
         $display("mismatch wait %0d expected 1 seen 0", k);
         wrap_up();
      end
   endtask : wait_until
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d, oe, got;
      int r, b;
      time t;
      repeat (8) @(posedge CLK);
      check("oe in reset", 16'(oe_n), 16'h00ff);
      check("ready in reset", 16'(ready_busy), 16'h0001);
      check("reset held", 16'(int_reset), 16'h0001);
      ARST_N <= 1'b1;
      wait_until(2, 5000);
      for (r = 0; r < NROWS; r++) begin
         fast <= ROWS[r].fast;
         check("done early", 16'(done), 16'h0000);
         acp_host_model_inst.write_byte(ROWS[r].data);
         wait_until(0, 20);
         if (!ROWS[r].fast) begin
            acp_host_model_inst.peek(1'b0, d, oe);
            check("busy oe", 16'(oe), 16'h0000);
            check("busy status", 16'(d), 16'h007f);
            // Write during busy must be lost
            acp_host_model_inst.write_byte(8'h00);
         end
         wait_until(1, 600);
         acp_host_model_inst.peek(1'b0, d, oe);
         check("ready status", 16'(d), 16'h00ff);
         acp_host_model_inst.peek(1'b1, d, oe);
         check("idle oe", 16'(oe), 16'h007f);
         check("idle bit 7", 16'(d[7]), 16'h0001);
      end
      wait_until(5, 3000);
      for (r = 0; r < NROWS; r++) begin
         for (b = 0; b < 8; b++) got[7 - b] = bits.pop_front();
         check("serial byte", 16'(got), 16'(ROWS[r].data));
      end
      wait_until(3, 500);
      check("reset released", 16'(int_reset), 16'h0000);
      program_n <= 1'b0;
      ext_hold <= 1'b1;
      mode_bits <= 3'h4;
      len_count <= 16'h0001;
      repeat (10) @(posedge CLK);
      check("init pulled", 16'(init_oe_n), 16'h0000);
      check("init level", 16'(init_out), 16'h0000);
      check("clearing", 16'(mem_clear), 16'h0001);
      program_n <= 1'b1;
      repeat (200) @(posedge CLK);
      check("clear over", 16'(mem_clear), 16'h0000);
      check("init let go", 16'(init_oe_n), 16'h0001);
      acp_host_model_inst.write_byte(8'h55);
      repeat (6) @(posedge CLK);
      check("write ignored", 16'(ready_busy), 16'h0001);
      ext_hold <= 1'b0;
      wait_until(4, 50);
      t = $time;
      wait_until(2, 5000);
      check("clock start", 16'(($time - t) / CLK_PERIOD_NS), 16'(CONFIG_CLOCK_DELAY_CYC + HALF_FAST_CYC + 10));
      check("no stray bits", 16'(bits.size()), 16'h0000);
      check("short length", 16'(done), 16'h0000);
      acp_host_model_inst.write_byte(8'h96);
      wait_until(3, 900);
      repeat (20) @(posedge CLK);
      for (b = 0; b < 8; b++) got[7 - b] = bits.pop_front();
      check("last byte", 16'(got), 16'h0096);
      wrap_up();
   end
endmodule : tb
